// ### src/uwl_pkg.sv
package uwl_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int XLEN = 64;
	localparam int WORD_W = 32;
	localparam int OFS_W = 16;
	localparam int BYTE_W = 8;
	localparam int LANES = 4;
	localparam int DEST_W = 5;

	// ----------------------------------------------------------------
	// address fields and fixed values
	// ----------------------------------------------------------------
	localparam int DW_LOW_W = 3;
	localparam logic [1:0] WORD_ALIGN_OK = 2'h0;
	localparam logic [2:0] DW_BASE = 3'h0;
	localparam logic [1:0] SEL_FIRST = 2'h0;
	localparam logic [1:0] SEL_LAST = 2'h3;
	localparam logic [31:0] UPPER_ZERO = 32'h0000_0000;
	localparam logic KEEP_UPPER_DEFAULT = 1'b0;

	// ----------------------------------------------------------------
	// operations and states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_LOAD_WORD_LEFT_PART = 2'h0,
		OP_LOAD_WORD_RIGHT_PART = 2'h1,
		OP_LOAD_WORD_ZERO_EXTEND = 2'h2,
		OP_INDEXED_FP_WORD_LOAD = 2'h3
	} uwl_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1
	} uwl_state_t;
endpackage

// ### src/uwl_merge_if.sv
interface uwl_merge_if;
	logic is_left;
	logic [1:0] byte_sel;
	logic [uwl_pkg::WORD_W-1:0] mem_word;
	logic [uwl_pkg::WORD_W-1:0] old_word;
	logic [uwl_pkg::WORD_W-1:0] merged;
	// high for the left part always, for the right part only when byte_sel is 0
	logic sign_loaded;

	modport ctrl (
		output is_left,
		output byte_sel,
		output mem_word,
		output old_word,
		input merged,
		input sign_loaded
	);

	modport merger (
		input is_left,
		input byte_sel,
		input mem_word,
		input old_word,
		output merged,
		output sign_loaded
	);
endinterface

// ### src/uwl_byte_merge.sv
module uwl_byte_merge (
	// merge request and result
	uwl_merge_if.merger m
);
	// ----------------------------------------------------------------
	// per-lane byte steering
	// ----------------------------------------------------------------
	// lane + sel >= 3 means the lane lies in the loaded part of a left
	// load; lane + sel <= 3 likewise for a right load
	genvar i;
	generate
		for (i = 0; i < uwl_pkg::LANES; i++) begin : g_lane
			localparam logic [2:0] LANE = 3'(i);
			wire [2:0] sum = LANE + {1'b0, m.byte_sel};
			wire left_take = sum >= 3'h3;
			wire right_take = sum <= 3'h3;
			wire take = m.is_left ? left_take : right_take;
			wire [1:0] src = m.is_left ? (sum[1:0] + 2'h1) : sum[1:0];
			wire [7:0] src_byte = m.mem_word[src*uwl_pkg::BYTE_W +: 8];
			wire [7:0] old_byte = m.old_word[i*uwl_pkg::BYTE_W +: 8];
			assign m.merged[i*uwl_pkg::BYTE_W +: 8] =
				take ? src_byte : old_byte;
		end
	endgenerate

	assign m.sign_loaded = m.is_left || (m.byte_sel == uwl_pkg::SEL_FIRST);
endmodule

// ### src/uwl_load_merge.sv
// How it works
// - left load sign-fills upper thirty-two bits
// - left load fills high bytes, keeps low
// - right address marks lowest byte of word
// - right load writes bytes into low part
// - right load keeps untouched high bytes
// - full right load copies bit 31 upward
// - partial right: keep upper or copy 31
// - left plus right gives sign-extended word
// - address is base plus sign-extended offset
// - bytes chosen by offset and endianness
// - partial load to little-endian memory clears low address bits
// - unsigned load zero-fills upper bits
// - misaligned unsigned load faults, no access
// - unsigned load may raise reserved instruction
// - indexed address is base plus index
// - indexed load writes low float word
// - indexed load upper bits left zero
// - misaligned indexed load raises address error
// - partial loads never zero-extend
// - back-to-back partial loads merge forwarded data
module uwl_load_merge #(
	parameter logic KEEP_UPPER = uwl_pkg::KEEP_UPPER_DEFAULT
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// request from the load/store pipeline
	input wire logic req_valid_i,
	input wire uwl_pkg::uwl_op_t req_op_i,
	input wire logic [uwl_pkg::DEST_W-1:0] req_dest_i,
	input wire logic [uwl_pkg::XLEN-1:0] req_base_i,
	input wire logic [uwl_pkg::XLEN-1:0] req_index_i,
	input wire logic [uwl_pkg::OFS_W-1:0] req_offset_i,
	input wire logic [uwl_pkg::XLEN-1:0] req_old_value_i,
	input wire logic cpu_big_endian_flag_i,
	input wire logic endian_reverse_flag_i,
	input wire logic memory_big_endian_flag_i,
	input wire logic zero_extend_enable_i,
	output logic ready_o,
	// data memory
	output logic mem_req_o,
	output logic [uwl_pkg::XLEN-1:0] mem_addr_o,
	input wire logic mem_rvalid_i,
	input wire logic [uwl_pkg::XLEN-1:0] mem_rdata_i,
	// writeback
	output logic wb_valid_o,
	output logic [uwl_pkg::DEST_W-1:0] wb_dest_o,
	output logic wb_float_o,
	output logic [uwl_pkg::XLEN-1:0] wb_data_o,
	output logic addr_error_o,
	output logic reserved_instr_o
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	uwl_pkg::uwl_state_t state;
	uwl_pkg::uwl_state_t next_state;
	uwl_pkg::uwl_op_t op_q;
	logic [uwl_pkg::XLEN-1:0] old_q;
	logic [uwl_pkg::XLEN-1:0] ea_q;
	logic [1:0] bsel_q;
	logic half_q;
	logic fwd_valid;
	logic [uwl_pkg::DEST_W-1:0] fwd_dest;
	logic [uwl_pkg::XLEN-1:0] fwd_data;

	uwl_merge_if mg ();

	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	wire take = req_valid_i && ready_o;
	wire is_left = req_op_i == uwl_pkg::OP_LOAD_WORD_LEFT_PART;
	wire is_right = req_op_i == uwl_pkg::OP_LOAD_WORD_RIGHT_PART;
	wire is_zext = req_op_i == uwl_pkg::OP_LOAD_WORD_ZERO_EXTEND;
	wire is_fp = req_op_i == uwl_pkg::OP_INDEXED_FP_WORD_LOAD;
	wire is_part = is_left || is_right;

	wire [uwl_pkg::XLEN-1:0] offset_ext = {
		{(uwl_pkg::XLEN - uwl_pkg::OFS_W){req_offset_i[uwl_pkg::OFS_W-1]}},
		req_offset_i
	};
	wire [uwl_pkg::XLEN-1:0] ea_offset = req_base_i + offset_ext;
	wire [uwl_pkg::XLEN-1:0] ea_index = req_base_i + req_index_i;
	wire [uwl_pkg::XLEN-1:0] virtual_address =
		is_fp ? ea_index : ea_offset;

	// partial loads are allowed at any byte; the others must be aligned
	wire misalign = virtual_address[1:0] != uwl_pkg::WORD_ALIGN_OK;
	wire align_fault = !is_part && misalign;
	wire rsvd_fault = is_zext && !zero_extend_enable_i;
	wire fault = align_fault || rsvd_fault;
	wire issue = take && !fault;

	// ----------------------------------------------------------------
	// memory address
	// ----------------------------------------------------------------
	// no translation here: the virtual address goes out as is, with the
	// reverse-endian swap of the low bits applied, or those bits cleared for a partial load to little-endian memory
	wire [2:0] part_swap = {3{endian_reverse_flag_i}};
	wire [2:0] word_swap = {endian_reverse_flag_i, 2'h0};
	wire [2:0] low_swapped = virtual_address[2:0] ^
		(is_part ? part_swap : word_swap);
	wire clear_low = is_part && !memory_big_endian_flag_i;
	wire [2:0] low_final = clear_low ? uwl_pkg::DW_BASE : low_swapped;
	wire [uwl_pkg::XLEN-1:0] phys_addr = {
		virtual_address[uwl_pkg::XLEN-1:uwl_pkg::DW_LOW_W],
		low_final
	};

	// ----------------------------------------------------------------
	// byte and half selection
	// ----------------------------------------------------------------
	// the same half flip serves aligned and partial words
	wire [1:0] byte_sel =
		virtual_address[1:0] ^ {2{cpu_big_endian_flag_i}};
	wire half_sel = virtual_address[2] ^ cpu_big_endian_flag_i;

	// ----------------------------------------------------------------
	// forwarding between back-to-back partial loads
	// ----------------------------------------------------------------
	// the pipeline's copy of the old value may still be stale when a
	// partial load follows one to the same register, so use our own
	wire fwd_hit = is_part && fwd_valid && (fwd_dest == req_dest_i);
	wire [uwl_pkg::XLEN-1:0] old_sel =
		fwd_hit ? fwd_data : req_old_value_i;

	// ----------------------------------------------------------------
	// result forming
	// ----------------------------------------------------------------
	wire finish = (state == uwl_pkg::ST_WAIT) && mem_rvalid_i;
	wire [uwl_pkg::WORD_W-1:0] mem_word = half_q ?
		mem_rdata_i[uwl_pkg::XLEN-1:uwl_pkg::WORD_W] :
		mem_rdata_i[uwl_pkg::WORD_W-1:0];

	assign mg.is_left = op_q == uwl_pkg::OP_LOAD_WORD_LEFT_PART;
	assign mg.byte_sel = bsel_q;
	assign mg.mem_word = mem_word;
	assign mg.old_word = old_q[uwl_pkg::WORD_W-1:0];

	uwl_byte_merge u_merge (
		.m(mg)
	);

	wire [uwl_pkg::WORD_W-1:0] sign_fill =
		{uwl_pkg::WORD_W{mg.merged[uwl_pkg::WORD_W-1]}};
	wire [uwl_pkg::WORD_W-1:0] right_keep = KEEP_UPPER ?
		old_q[uwl_pkg::XLEN-1:uwl_pkg::WORD_W] :
		{uwl_pkg::WORD_W{old_q[uwl_pkg::WORD_W-1]}};
	// either order of left and right ends sign-extended, since the left
	// part always fills and a partial right part keeps bit 31 unchanged
	wire [uwl_pkg::WORD_W-1:0] part_upper =
		mg.sign_loaded ? sign_fill : right_keep;
	wire [uwl_pkg::XLEN-1:0] part_result = {part_upper, mg.merged};
	// upper float bits are free; zero keeps the result deterministic
	wire [uwl_pkg::XLEN-1:0] word_result =
		{uwl_pkg::UPPER_ZERO, mem_word};
	wire op_q_part = (op_q == uwl_pkg::OP_LOAD_WORD_LEFT_PART) ||
		(op_q == uwl_pkg::OP_LOAD_WORD_RIGHT_PART);
	wire [uwl_pkg::XLEN-1:0] result = op_q_part ? part_result : word_result;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			uwl_pkg::ST_IDLE: begin
				if (issue) begin
					next_state = uwl_pkg::ST_WAIT;
				end
			end
			uwl_pkg::ST_WAIT: begin
				if (mem_rvalid_i) begin
					next_state = uwl_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = uwl_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state <= uwl_pkg::ST_IDLE;
			ready_o <= 1'b1;
		end else begin
			state <= next_state;
			ready_o <= next_state == uwl_pkg::ST_IDLE;
		end
	end

	// request fields are captured once, at take
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			op_q <= uwl_pkg::OP_LOAD_WORD_LEFT_PART;
			old_q <= '0;
			ea_q <= '0;
			bsel_q <= 2'h0;
			half_q <= 1'b0;
		end else if (take) begin
			op_q <= req_op_i;
			old_q <= old_sel;
			ea_q <= virtual_address;
			bsel_q <= byte_sel;
			half_q <= half_sel;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			mem_req_o <= 1'b0;
			mem_addr_o <= '0;
		end else begin
			mem_req_o <= issue;
			if (issue) begin
				mem_addr_o <= phys_addr;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			wb_valid_o <= 1'b0;
			addr_error_o <= 1'b0;
			reserved_instr_o <= 1'b0;
		end else begin
			wb_valid_o <= (take && fault) || finish;
			// decode fault outranks the address check
			addr_error_o <= take && align_fault && !rsvd_fault;
			reserved_instr_o <= take && rsvd_fault;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			wb_dest_o <= '0;
			wb_float_o <= 1'b0;
			wb_data_o <= '0;
		end else begin
			if (take) begin
				wb_dest_o <= req_dest_i;
				wb_float_o <= is_fp;
			end
			if (finish) begin
				wb_data_o <= result;
			end
		end
	end

	// only the load right before may forward
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			fwd_valid <= 1'b0;
			fwd_dest <= '0;
			fwd_data <= '0;
		end else if (finish) begin
			fwd_valid <= op_q_part;
			fwd_dest <= wb_dest_o;
			fwd_data <= result;
		end else if (take) begin
			fwd_valid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_left_sign_fill: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		finish && op_q == uwl_pkg::OP_LOAD_WORD_LEFT_PART |=>
		wb_valid_o && wb_data_o[63:32] == {32{wb_data_o[31]}})
		else $error("left load upper bits not sign filled");

	chk_left_byte_place: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		finish && op_q == uwl_pkg::OP_LOAD_WORD_LEFT_PART &&
		bsel_q == uwl_pkg::SEL_FIRST |->
		result[31:24] == mem_word[7:0] && result[23:0] == old_q[23:0])
		else $error("left load bytes misplaced");

	chk_right_byte_place: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		finish && op_q == uwl_pkg::OP_LOAD_WORD_RIGHT_PART &&
		bsel_q == uwl_pkg::SEL_LAST |->
		result[7:0] == mem_word[31:24] && result[31:8] == old_q[31:8])
		else $error("right load bytes misplaced");

	chk_right_full_sign: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		finish && op_q == uwl_pkg::OP_LOAD_WORD_RIGHT_PART &&
		bsel_q == uwl_pkg::SEL_FIRST |->
		result == {{32{mem_word[31]}}, mem_word})
		else $error("full right load not sign extended");

	chk_right_part_upper: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		finish && op_q == uwl_pkg::OP_LOAD_WORD_RIGHT_PART &&
		bsel_q != uwl_pkg::SEL_FIRST |->
		result[63:32] == (KEEP_UPPER ? old_q[63:32] : {32{old_q[31]}}))
		else $error("partial right load upper bits wrong");

	chk_zext_upper_zero: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		finish && op_q == uwl_pkg::OP_LOAD_WORD_ZERO_EXTEND |=>
		wb_data_o == {32'h0000_0000, $past(mem_word)})
		else $error("unsigned load not zero extended");

	chk_zext_misalign: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		take && is_zext && zero_extend_enable_i && misalign |=>
		// a fault never drops ready; the cycle after may take anew
		wb_valid_o && addr_error_o && !mem_req_o && ready_o)
		else $error("misaligned unsigned load not faulted");

	chk_fp_misalign: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		take && is_fp && misalign |=>
		addr_error_o && wb_valid_o && !mem_req_o)
		else $error("misaligned indexed load not faulted");

	chk_le_addr_clear: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		take && is_part && !memory_big_endian_flag_i |=>
		mem_req_o && mem_addr_o[2:0] == 3'h0 &&
		mem_addr_o[63:3] == ea_q[63:3])
		else $error("little endian partial address not cleared");

	chk_fp_low_word: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		finish && op_q == uwl_pkg::OP_INDEXED_FP_WORD_LOAD |=>
		wb_float_o && wb_data_o[31:0] == $past(mem_word))
		else $error("indexed load low word wrong");

	chk_fwd_merge: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		take && fwd_hit |=> old_q == $past(fwd_data))
		else $error("back to back partial load not forwarded");

	chk_rsvd_no_access: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		take && rsvd_fault |=>
		reserved_instr_o && !addr_error_o && !mem_req_o)
		else $error("reserved unsigned load not refused");
endmodule

// ### tb/uwl_mem_model.sv
module uwl_mem_model #(
	parameter logic [63:0] DW = 64'h8A9B_ACBD_4152_6374
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// read port as seen from memory
	input wire logic mem_req_i,
	output logic mem_rvalid_o,
	output logic [63:0] mem_rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// latency walks 0..3 cycles so prompt and slow answers both occur
	// ----------------------------------------------------------------
	logic pend;
	logic [1:0] dly;
	logic [1:0] cnt;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			pend <= 1'b0;
			dly <= 2'h0;
			cnt <= 2'h0;
		end else if (mem_req_i) begin
			dly <= dly + 2'h1;
			pend <= (dly != 2'h0);
			cnt <= dly;
		end else if (pend) begin
			cnt <= cnt - 2'h1;
			if (cnt == 2'h1) begin
				pend <= 1'b0;
			end
		end
	end

	assign mem_rvalid_o = (mem_req_i && dly == 2'h0) ||
		(pend && cnt == 2'h1);
	// outside the valid cycle the bus shows inverted data, never a held copy
	assign mem_rdata_o = mem_rvalid_o ? DW : ~DW;
endmodule

// ### tb/test_uwl_load_merge.sv
module test_uwl_load_merge;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [63:0] DW = 64'h8A9B_ACBD_4152_6374;
	localparam logic [63:0] OLD = 64'h5A5A_5A5A_C3C3_C3C3;

	logic clk_i, reset_n_i, req_valid_i, ready_o, mem_req_o, mem_rvalid_i;
	logic cpu_big_endian_flag_i, endian_reverse_flag_i;
	logic memory_big_endian_flag_i, zero_extend_enable_i;
	logic wb_valid_o, wb_float_o, addr_error_o, reserved_instr_o;
	uwl_pkg::uwl_op_t req_op_i;
	logic [4:0] req_dest_i, wb_dest_o;
	logic [15:0] req_offset_i;
	logic [63:0] req_base_i, req_index_i, req_old_value_i;
	logic [63:0] mem_addr_o, mem_rdata_i, wb_data_o, got_addr;
	int errors, num_checks, got_n;

	uwl_load_merge i_uwl_load_merge (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
		.req_op_i(req_op_i), .req_dest_i(req_dest_i),
		.req_base_i(req_base_i), .req_index_i(req_index_i),
		.req_offset_i(req_offset_i), .req_old_value_i(req_old_value_i),
		.cpu_big_endian_flag_i(cpu_big_endian_flag_i),
		.endian_reverse_flag_i(endian_reverse_flag_i),
		.memory_big_endian_flag_i(memory_big_endian_flag_i),
		.zero_extend_enable_i(zero_extend_enable_i), .ready_o(ready_o),
		.mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
		.mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i),
		.wb_valid_o(wb_valid_o), .wb_dest_o(wb_dest_o),
		.wb_float_o(wb_float_o), .wb_data_o(wb_data_o),
		.addr_error_o(addr_error_o), .reserved_instr_o(reserved_instr_o)
	);

	uwl_mem_model #(.DW(DW)) i_uwl_mem_model (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .mem_req_i(mem_req_o),
		.mem_rvalid_o(mem_rvalid_i), .mem_rdata_o(mem_rdata_i)
	);

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// reference model
	// ----------------------------------------------------------------
	function automatic logic [63:0] res(uwl_pkg::uwl_op_t op,
			logic [63:0] va, logic big, logic [63:0] old);
		logic [31:0] w, lo;
		logic [1:0] s;
		w = (va[2] ^ big) ? DW[63:32] : DW[31:0];
		s = va[1:0] ^ {2{big}};
		if (op == uwl_pkg::OP_LOAD_WORD_LEFT_PART) begin
			lo = (w << (8 * (3 - s))) |
				(old[31:0] & (32'hFFFFFFFF >> (8 * (s + 1))));
			return {{32{lo[31]}}, lo};
		end
		if (op == uwl_pkg::OP_LOAD_WORD_RIGHT_PART) begin
			lo = (w >> (8 * s)) |
				(old[31:0] & ~(32'hFFFFFFFF >> (8 * s)));
			// upper copy of bit 31 whether loaded or kept
			return {{32{lo[31]}}, lo};
		end
		return {32'h0, w};
	endfunction

	function automatic logic [63:0] maddr(logic part, logic [63:0] va,
			logic rev, logic mb);
		logic [63:0] a;
		a = va;
		if (part) a[2:0] = mb ? (va[2:0] ^ {3{rev}}) : 3'h0;
		else a[2] = va[2] ^ rev;
		return a;
	endfunction

	task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up;
		if (errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// valid stays high between calls; fields held until the result
	task automatic go(uwl_pkg::uwl_op_t op, logic [4:0] d, logic [63:0] b, x,
			logic [15:0] o, logic [63:0] old, logic big, rev, mb, zen);
		logic done;
		req_op_i = op;
		req_dest_i = d;
		req_base_i = b;
		req_index_i = x;
		req_offset_i = o;
		req_old_value_i = old;
		cpu_big_endian_flag_i = big;
		endian_reverse_flag_i = rev;
		memory_big_endian_flag_i = mb;
		zero_extend_enable_i = zen;
		req_valid_i = 1'b1;
		done = 1'b0;
		got_n = 0;
		@(posedge clk_i);
		for (int k = 0; k < 20 && !done; k++) begin
			@(negedge clk_i);
			if (mem_req_o === 1'b1) begin
				got_n++;
				got_addr = mem_addr_o;
			end
			if (wb_valid_o === 1'b1) done = 1'b1;
		end
		check("wb_valid_o", {63'h0, done}, 64'h1);
		check("ready_o", {63'h0, ready_o}, 64'h1);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_partial;
		logic [63:0] va, b;
		logic [15:0] o;
		uwl_pkg::uwl_op_t op;
		for (int i = 0; i < 32; i++) begin
			op = i[0] ? uwl_pkg::OP_LOAD_WORD_RIGHT_PART
				: uwl_pkg::OP_LOAD_WORD_LEFT_PART;
			b = 64'h1_0000_0100 + 64'(i * 4);
			o = 16'hFFFC + 16'(i[2:1]);
			va = b + {{48{o[15]}}, o};
			go(op, 5'(i), b, 64'hFFFF_0000_0000_0000, o, OLD, i[3], i[4],
				i[3] ^ i[4], 1'b1);
			check("wb_data_o", wb_data_o,
				res(op, va, i[3], OLD));
			check("mem_addr_o", got_addr,
				maddr(1'b1, va, i[4], i[3] ^ i[4]));
			check("mem_req_count", 64'(got_n), 64'h1);
			check("wb_dest_o", 64'(wb_dest_o), 64'(i));
			check("fault_flags", {62'h0, addr_error_o, reserved_instr_o},
				64'h0);
		end
	endtask

	task automatic t_pair;
		logic [63:0] b;
		logic [15:0] f1, f2;
		uwl_pkg::uwl_op_t o1, o2;
		b = 64'h2000_0000;
		for (int j = 0; j < 2; j++) begin
			o1 = j ? uwl_pkg::OP_LOAD_WORD_RIGHT_PART
				: uwl_pkg::OP_LOAD_WORD_LEFT_PART;
			o2 = j ? uwl_pkg::OP_LOAD_WORD_LEFT_PART
				: uwl_pkg::OP_LOAD_WORD_RIGHT_PART;
			f1 = j ? 16'h0005 : 16'h0002;
			f2 = j ? 16'h0002 : 16'h0005;
			go(o1, 5'(7 + j), b, 64'h0, f1, OLD, 1'b1, 1'b0, 1'b1, 1'b1);
			check("wb_data_o", wb_data_o,
				res(o1, b + 64'(f1), 1'b1, OLD));
			// stale old value: the merge must use the previous result
			go(o2, 5'(7 + j), b, 64'h0, f2, OLD, 1'b1, 1'b0, 1'b1, 1'b1);
			check("wb_data_o", wb_data_o, 64'hFFFF_FFFF_ACBD_4152);
		end
	endtask

	task automatic t_zero;
		logic [63:0] va, b, keep;
		logic [15:0] o;
		logic zen, err;
		b = 64'h3000_0004;
		for (int j = 0; j < 6; j++) begin
			zen = (j < 4);
			o = 16'h0010 + 16'(j % 4);
			va = b + 64'(o);
			err = zen && (j % 4 != 0);
			if (j == 0) keep = res(uwl_pkg::OP_LOAD_WORD_ZERO_EXTEND, va,
				1'b1, OLD);
			go(uwl_pkg::OP_LOAD_WORD_ZERO_EXTEND, 5'h3, b, 64'h0, o, OLD,
				1'b1, 1'b1, 1'b1, zen);
			check("wb_data_o", wb_data_o, keep);
			check("mem_req_count", 64'(got_n), 64'(j == 0));
			check("fault_flags", {62'h0, addr_error_o, reserved_instr_o},
				{62'h0, err, !zen});
			check("wb_float_o", {63'h0, wb_float_o}, 64'h0);
			check("wb_dest_o", 64'(wb_dest_o), 64'h3);
			if (j == 0) check("mem_addr_o", got_addr,
				maddr(1'b0, va, 1'b1, 1'b1));
		end
	endtask

	task automatic t_index;
		logic [63:0] va, b, x, keep;
		b = 64'h4000_0000;
		for (int j = 0; j < 4; j++) begin
			x = 64'h0104 + 64'(j);
			va = b + x;
			if (j == 0) keep = res(uwl_pkg::OP_INDEXED_FP_WORD_LOAD, va,
				1'b0, OLD);
			go(uwl_pkg::OP_INDEXED_FP_WORD_LOAD, 5'h4, b, x, 16'h7FF0, OLD,
				1'b0, 1'b1, 1'b1, 1'b1);
			check("wb_data_o", wb_data_o, keep);
			check("wb_float_o", {63'h0, wb_float_o}, 64'h1);
			check("mem_req_count", 64'(got_n), 64'(j == 0));
			check("fault_flags", {62'h0, addr_error_o, reserved_instr_o},
				{62'h0, j != 0, 1'b0});
			if (j == 0) check("mem_addr_o", got_addr,
				maddr(1'b0, va, 1'b1, 1'b1));
		end
	endtask

	initial begin
		errors = 0;
		num_checks = 0;
		reset_n_i = 1'b0;
		req_valid_i = 1'b0;
		req_op_i = uwl_pkg::OP_LOAD_WORD_LEFT_PART;
		req_dest_i = 5'h0;
		req_base_i = 64'h0;
		req_index_i = 64'h0;
		req_offset_i = 16'h0;
		req_old_value_i = 64'h0;
		cpu_big_endian_flag_i = 1'b0;
		endian_reverse_flag_i = 1'b0;
		memory_big_endian_flag_i = 1'b0;
		zero_extend_enable_i = 1'b0;
		repeat (12) @(negedge clk_i);
		reset_n_i = 1'b1;
		@(negedge clk_i);
		t_partial;
		t_pair;
		t_zero;
		t_index;
		req_valid_i = 1'b0;
		repeat (2) @(negedge clk_i);
		wrap_up;
	end

	// the whole run needs well under a thousand cycles
	initial begin
		#20000;
		errors++;
		wrap_up;
	end
endmodule
